// ---- rtl/adccr_pkg.sv ----
// shared constants and helpers for the converter control and result block
package adccr_pkg;

  // ************************************************************
  // register offsets on the host register port
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h15;
  localparam logic [7:0] ADDR_CHOFF    = 8'h16;
  localparam logic [7:0] ADDR_IIN_HI   = 8'h17;
  localparam logic [7:0] ADDR_IIN_LO   = 8'h18;
  localparam logic [7:0] ADDR_ICHG_HI  = 8'h19;
  localparam logic [7:0] ADDR_ICHG_LO  = 8'h1a;
  localparam logic [7:0] ADDR_VIN_HI   = 8'h1b;
  localparam logic [7:0] ADDR_VIN_LO   = 8'h1c;
  localparam logic [7:0] ADDR_REGRST   = 8'h25;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int         EN_BIT        = 7;
  localparam int         MODE_BIT      = 6;
  localparam int         SPEED_HI      = 5;
  localparam int         SPEED_LO      = 4;
  localparam int         REGRST_BIT    = 7;
  localparam int         DIR_BIT       = 7;
  localparam int         BYTE_W        = 8;
  localparam logic [7:0] CTRL_RST      = 8'h30;
  localparam logic [7:0] CHOFF_RST     = 8'h00;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  // bit 1 of the channel-disable register is reserved: no channel behind it
  localparam logic [7:0] CHAN_PRESENT  = 8'hfd;

  // ************************************************************
  // channels, result widths, resolution codes
  // ************************************************************
  localparam int         SAMPLE_W      = 16;
  localparam int         IIN_W         = 12;
  localparam int         ICHG_W        = 12;
  localparam int         VIN_W         = 13;
  localparam logic [2:0] CH_FIRST      = 3'h7;
  localparam logic [2:0] CH_LAST       = 3'h0;
  localparam logic [2:0] CH_IIN        = 3'h7;
  localparam logic [2:0] CH_ICHG       = 3'h6;
  localparam logic [2:0] CH_VIN        = 3'h5;
  localparam logic [1:0] SPEED_15      = 2'h0;
  localparam logic [1:0] SPEED_14      = 2'h1;
  localparam logic [1:0] SPEED_13      = 2'h2;
  localparam logic [3:0] RES_15        = 4'hf;
  localparam logic [3:0] RES_14        = 4'he;
  localparam logic [3:0] RES_13        = 4'hd;
  localparam logic [3:0] RES_12        = 4'hc;

  function automatic logic [3:0] adccr_res_bits(input logic [1:0] speed);
    case (speed)
      SPEED_15: adccr_res_bits = RES_15;
      SPEED_14: adccr_res_bits = RES_14;
      SPEED_13: adccr_res_bits = RES_13;
      default:  adccr_res_bits = RES_12;
    endcase
  endfunction : adccr_res_bits

endpackage : adccr_pkg

// ---- rtl/adccr_seq_if.sv ----
// carrier between the register core and the channel scanner
interface adccr_seq_if;
  logic       run;
  logic       one_shot;
  logic [7:0] chan_off;
  logic       pass_done;
  logic       res_valid;
  logic [2:0] res_chan;

  modport ctrl (output run, one_shot, chan_off, input pass_done, res_valid, res_chan);
  modport scan (input run, one_shot, chan_off, output pass_done, res_valid, res_chan);
endinterface : adccr_seq_if

// ---- rtl/adccr_result.sv ----
// one result value held as a high and a low byte, loaded in one step
module adccr_result
  import adccr_pkg::*;
#(
  parameter int DATA_W = 12
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // load side
  input  wire logic              clear,
  input  wire logic              load,
  input  wire logic [DATA_W-1:0] value,
  input  wire logic              flag,
  // read side
  output      logic [7:0]        hi_byte,
  output      logic [7:0]        lo_byte
);

  typedef struct packed {
    logic              flag;
    logic [DATA_W-1:0] value;
  } adccr_res_t;

  adccr_res_t r_r;
  adccr_res_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    if (clear) begin
      r_nxt = '0;
    end else if (load) begin
      r_nxt.value = value;
      r_nxt.flag  = flag;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // both bytes come from one register, so a read never mixes two conversions
  always_comb begin
    hi_byte          = BYTE_ZERO;
    hi_byte          = 8'(r_r.value >> BYTE_W);
    hi_byte[DIR_BIT] = r_r.flag;
    lo_byte          = r_r.value[BYTE_W-1:0];
  end

  // ************************************************************
  // checks
  // ************************************************************
  pair_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    (load && !clear) |=> (lo_byte == $past(value[BYTE_W-1:0])) && (hi_byte[DIR_BIT] == $past(flag)))
    else $error("result bytes do not match the loaded conversion");
  result_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    clear |=> (hi_byte == BYTE_ZERO) && (lo_byte == BYTE_ZERO))
    else $error("result not cleared by register reset");

endmodule : adccr_result

// ---- rtl/adccr_scan.sv ----
// channel scanner: walks enabled channels and requests one conversion each
module adccr_scan
  import adccr_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // core side
  adccr_seq_if.scan       seq,
  // converter side
  output      logic       conv_start,
  output      logic [2:0] conv_channel,
  input  wire logic       conv_ready
);

  typedef enum logic [1:0] {ST_IDLE, ST_FIND, ST_WAIT, ST_HOLD} adccr_scan_st_t;

  typedef struct packed {
    adccr_scan_st_t st;
    logic [2:0]     chan;
    logic           start;
    logic           pass_done;
    logic           res_valid;
    logic [2:0]     res_chan;
  } adccr_scan_t;

  adccr_scan_t s_r;
  adccr_scan_t s_nxt;
  logic        eligible;

  assign eligible = CHAN_PRESENT[s_r.chan] && !seq.chan_off[s_r.chan];

  always_comb begin
    s_nxt           = s_r;
    s_nxt.start     = 1'b0;
    s_nxt.pass_done = 1'b0;
    s_nxt.res_valid = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
        if (seq.run) begin
          s_nxt.st   = ST_FIND;
          s_nxt.chan = CH_FIRST;
        end
      end
      ST_FIND: begin
        if (!seq.run) begin
          s_nxt.st = ST_IDLE;
        end else if (eligible) begin
          s_nxt.start = 1'b1;
          s_nxt.st    = ST_WAIT;
        end else if (s_r.chan == CH_LAST) begin
          if (seq.one_shot) begin
            s_nxt.pass_done = 1'b1;
            s_nxt.st        = ST_HOLD;
          end else begin
            s_nxt.chan = CH_FIRST;
          end
        end else begin
          s_nxt.chan = s_r.chan - 3'h1;
        end
      end
      ST_WAIT: begin
        // a cleared enable abandons the conversion in flight
        if (!seq.run) begin
          s_nxt.st = ST_IDLE;
        end else if (conv_ready) begin
          s_nxt.res_valid = 1'b1;
          s_nxt.res_chan  = s_r.chan;
          if (s_r.chan == CH_LAST) begin
            if (seq.one_shot) begin
              s_nxt.pass_done = 1'b1;
              s_nxt.st        = ST_HOLD;
            end else begin
              s_nxt.chan = CH_FIRST;
              s_nxt.st   = ST_FIND;
            end
          end else begin
            s_nxt.chan = s_r.chan - 3'h1;
            s_nxt.st   = ST_FIND;
          end
        end
      end
      ST_HOLD: begin
        // wait for the core to drop the enable so one pass does not restart
        if (!seq.run) begin
          s_nxt.st = ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '{st: ST_IDLE, chan: CH_FIRST, res_chan: CH_FIRST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign conv_start    = s_r.start;
  assign conv_channel  = s_r.chan;
  assign seq.pass_done = s_r.pass_done;
  assign seq.res_valid = s_r.res_valid;
  assign seq.res_chan  = s_r.res_chan;

  // ************************************************************
  // checks
  // ************************************************************
  skip_disabled_a: assert property (@(posedge ref_clk) disable iff (rst)
    conv_start |-> (!seq.chan_off[conv_channel] && CHAN_PRESENT[conv_channel]))
    else $error("conversion requested on a disabled channel");
  oneshot_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_r.pass_done |=> (!s_r.start && !seq.run) ##1 !s_r.start)
    else $error("scanner started a conversion after finishing a pass");

endmodule : adccr_scan

// ---- rtl/adccr_core.sv ----
// converter control and result registers behind the host register port
module adccr_core
  import adccr_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // host register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_wdata,
  output      logic [7:0]          reg_rdata,
  // device status
  input  wire logic                watchdog_expired,
  input  wire logic                input_overvoltage_threshold,
  input  wire logic                adc_done_mask,
  // converter front end
  output      logic                conv_start,
  output      logic [2:0]          conv_channel,
  output      logic [3:0]          conv_res_bits,
  input  wire logic                conv_ready,
  input  wire logic [SAMPLE_W-1:0] conv_value,
  input  wire logic                conv_negative,
  // events and state
  output      logic                adc_done_pulse,
  output      logic                adc_enabled
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0]          ctrl;
    logic [7:0]          choff;
    logic                regrst;
    logic [7:0]          rdata;
    logic                done;
    logic                ov_s1;
    logic                ov_s2;
    logic [SAMPLE_W-1:0] cap_val;
    logic                cap_neg;
    logic [3:0]          res_bits;
  } adccr_core_t;

  adccr_core_t c_r;
  adccr_core_t c_nxt;

  adccr_seq_if seq ();

  logic       ld_iin;
  logic       ld_ichg;
  logic       ld_vin;
  logic [7:0] iin_hi;
  logic [7:0] iin_lo;
  logic [7:0] ichg_hi;
  logic [7:0] ichg_lo;
  logic [7:0] vin_hi;
  logic [7:0] vin_lo;
  logic       wr_ctrl;
  logic       wr_choff;
  logic       wr_regrst;

  assign wr_ctrl   = reg_wr && (reg_addr == ADDR_CTRL);
  assign wr_choff  = reg_wr && (reg_addr == ADDR_CHOFF);
  assign wr_regrst = reg_wr && (reg_addr == ADDR_REGRST) && reg_wdata[REGRST_BIT];

  assign seq.run      = c_r.ctrl[EN_BIT];
  assign seq.one_shot = c_r.ctrl[MODE_BIT];
  assign seq.chan_off = c_r.choff;

  assign ld_iin  = seq.res_valid && (seq.res_chan == CH_IIN);
  assign ld_ichg = seq.res_valid && (seq.res_chan == CH_ICHG);
  assign ld_vin  = seq.res_valid && (seq.res_chan == CH_VIN);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    c_nxt       = c_r;
    c_nxt.done  = 1'b0;
    c_nxt.ov_s1 = input_overvoltage_threshold;
    c_nxt.ov_s2 = c_r.ov_s1;
    if (wr_ctrl) begin
      c_nxt.ctrl = reg_wdata;
    end
    if (wr_choff) begin
      c_nxt.choff = reg_wdata;
    end
    if (wr_regrst) begin
      c_nxt.regrst = 1'b1;
    end
    if (conv_ready) begin
      c_nxt.cap_val = conv_value;
      c_nxt.cap_neg = conv_negative;
    end
    // hardware clears beat a software set in the same cycle
    if (watchdog_expired) begin
      c_nxt.ctrl[EN_BIT] = 1'b0;
    end
    if (c_r.ov_s2) begin
      c_nxt.ctrl[EN_BIT] = 1'b0;
    end
    if (seq.pass_done) begin
      c_nxt.ctrl[EN_BIT] = 1'b0;
      c_nxt.done         = c_r.ctrl[MODE_BIT] && !adc_done_mask;
    end
    if (c_r.regrst) begin
      c_nxt.ctrl   = CTRL_RST;
      c_nxt.choff  = CHOFF_RST;
      c_nxt.regrst = 1'b0;
    end
    c_nxt.res_bits = adccr_res_bits(c_nxt.ctrl[SPEED_HI:SPEED_LO]);
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL:    c_nxt.rdata = c_r.ctrl;
        ADDR_CHOFF:   c_nxt.rdata = c_r.choff;
        ADDR_IIN_HI:  c_nxt.rdata = iin_hi;
        ADDR_IIN_LO:  c_nxt.rdata = iin_lo;
        ADDR_ICHG_HI: c_nxt.rdata = ichg_hi;
        ADDR_ICHG_LO: c_nxt.rdata = ichg_lo;
        ADDR_VIN_HI:  c_nxt.rdata = vin_hi;
        ADDR_VIN_LO:  c_nxt.rdata = vin_lo;
        ADDR_REGRST:  c_nxt.rdata = 8'(c_r.regrst) << REGRST_BIT;
        default:      c_nxt.rdata = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c_r <= '{ctrl: CTRL_RST, choff: CHOFF_RST, res_bits: RES_12, default: '0};
    end else begin
      c_r <= c_nxt;
    end
  end

  assign reg_rdata      = c_r.rdata;
  assign adc_done_pulse = c_r.done;
  assign adc_enabled    = c_r.ctrl[EN_BIT];
  assign conv_res_bits  = c_r.res_bits;

  // ************************************************************
  // scanner and result registers
  // ************************************************************
  adccr_scan u_scan (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .seq          (seq.scan),
    .conv_start   (conv_start),
    .conv_channel (conv_channel),
    .conv_ready   (conv_ready)
  );

  // only the input current carries a direction flag
  adccr_result #(.DATA_W(IIN_W)) u_iin (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clear   (c_r.regrst),
    .load    (ld_iin),
    .value   (c_r.cap_val[IIN_W-1:0]),
    .flag    (c_r.cap_neg),
    .hi_byte (iin_hi),
    .lo_byte (iin_lo)
  );

  adccr_result #(.DATA_W(ICHG_W)) u_ichg (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clear   (c_r.regrst),
    .load    (ld_ichg),
    .value   (c_r.cap_val[ICHG_W-1:0]),
    .flag    (1'b0),
    .hi_byte (ichg_hi),
    .lo_byte (ichg_lo)
  );

  adccr_result #(.DATA_W(VIN_W)) u_vin (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clear   (c_r.regrst),
    .load    (ld_vin),
    .value   (c_r.cap_val[VIN_W-1:0]),
    .flag    (1'b0),
    .hi_byte (vin_hi),
    .lo_byte (vin_lo)
  );

  // ************************************************************
  // checks
  // ************************************************************
  watchdog_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    watchdog_expired |=> !adc_enabled)
    else $error("watchdog expiry did not clear the enable");
  overvolt_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    input_overvoltage_threshold ##1 input_overvoltage_threshold ##1 input_overvoltage_threshold
      |=> !adc_enabled)
    else $error("over-voltage did not clear the enable");
  speed_res_a: assert property (@(posedge ref_clk) disable iff (rst)
    conv_res_bits == adccr_res_bits(c_r.ctrl[SPEED_HI:SPEED_LO]))
    else $error("resolution does not follow the sample-speed field");
  done_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    adc_done_pulse |-> $past(seq.pass_done) && $past(c_r.ctrl[MODE_BIT]) && !$past(adc_done_mask))
    else $error("done pulse outside one-shot or while masked");
  oneshot_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
    (seq.pass_done && !c_r.regrst) |=> !adc_enabled)
    else $error("one-shot pass left the enable set");
  regrst_cycle_a: assert property (@(posedge ref_clk) disable iff (rst)
    c_r.regrst |=> !c_r.regrst && (c_r.ctrl == CTRL_RST) && (c_r.choff == CHOFF_RST))
    else $error("register reset did not restore defaults");
  result_ro_a: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_wr && (reg_addr == ADDR_IIN_LO) && !ld_iin && !c_r.regrst) |=> $stable(iin_lo))
    else $error("result register changed on a host write");
  dir_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ld_iin && !c_r.regrst) |=> iin_hi[DIR_BIT] == $past(c_r.cap_neg))
    else $error("direction bit does not follow the conversion");
  enable_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_ctrl && reg_wdata[EN_BIT] && !watchdog_expired && !c_r.ov_s2 && !seq.pass_done && !c_r.regrst)
      |=> adc_enabled)
    else $error("enable write did not take effect");
  choff_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_choff && !c_r.regrst) |=> (c_r.choff == $past(reg_wdata)))
    else $error("channel-disable write did not take effect");
  regrst_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_regrst && !c_r.regrst) |=> c_r.regrst)
    else $error("register-reset bit not raised by a host write");
  result_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_wr && (reg_addr >= ADDR_IIN_HI) && (reg_addr <= ADDR_VIN_LO) && !seq.res_valid && !c_r.regrst)
      |=> $stable({iin_hi, iin_lo, ichg_hi, ichg_lo, vin_hi, vin_lo}))
    else $error("result bytes changed on a host write");

endmodule : adccr_core

// ---- verif/adccr_core_tb.sv ----
// self-checking bench for the converter control and result registers
module adccr_core_tb
  import adccr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                ref_clk, rst, reg_wr, reg_rd, rd_taken;
  logic                watchdog_expired, input_overvoltage_threshold, adc_done_mask;
  logic                conv_start, conv_ready, conv_negative, adc_done_pulse, adc_enabled;
  logic [7:0]          reg_addr, reg_wdata, reg_rdata, exp_b, off_r;
  logic [2:0]          conv_channel, ch;
  logic [3:0]          conv_res_bits;
  logic [SAMPLE_W-1:0] conv_value;
  logic [SAMPLE_W-1:0] vals [8];
  logic                negs [8];
  logic [7:0]          q [$];
  int                  cnt [8];
  int                  errors, total_checks, done_cnt, n, done0;

  adccr_core i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .watchdog_expired(watchdog_expired),
    .input_overvoltage_threshold(input_overvoltage_threshold), .adc_done_mask(adc_done_mask),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_res_bits(conv_res_bits),
    .conv_ready(conv_ready), .conv_value(conv_value), .conv_negative(conv_negative),
    .adc_done_pulse(adc_done_pulse), .adc_enabled(adc_enabled));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ************************************************************
  // checking and host port tasks
  // ************************************************************
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  // the strobe idles one cycle between calls, so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    q.push_back(e);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge ref_clk);
    reg_rd   = 1'b0;
  endtask : rd

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // ************************************************************
  // result watcher and converter responder
  // ************************************************************
  always @(posedge ref_clk) rd_taken <= reg_rd & ~rst;

  always @(negedge ref_clk) begin
    if (rd_taken) begin
      exp_b = q.pop_front();
      chk(exp_b, reg_rdata);
    end
    if (adc_done_pulse === 1'b1) done_cnt++;
  end

  // answers each request after a random wait; upper value bits carry junk on purpose
  always begin : resp
    @(negedge ref_clk);
    if (conv_start === 1'b1) begin
      ch = conv_channel;
      cnt[ch]++;
      repeat ($urandom_range(3, 0)) @(negedge ref_clk);
      conv_ready    = 1'b1;
      conv_value    = vals[ch];
      conv_negative = negs[ch];
      @(negedge ref_clk);
      conv_ready    = 1'b0;
      conv_value    = ~conv_value;
      conv_negative = ~conv_negative;
    end
  end

  initial begin
    repeat (50000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end

  // ************************************************************
  // scenario helpers
  // ************************************************************
  task automatic idle(input int c);
    repeat (c) @(negedge ref_clk);
  endtask : idle

  task automatic chk_en(input logic e);
    chk({7'h0, e}, {7'h0, adc_enabled});
  endtask : chk_en

  // one-shot pass: each enabled channel once, then the enable drops by itself
  task automatic one_shot(input logic [7:0] off, input logic m, input logic [1:0] s);
    for (int i = 0; i < 8; i++) begin
      vals[i] = SAMPLE_W'($urandom);
      negs[i] = 1'($urandom);
      cnt[i]  = 0;
    end
    adc_done_mask = m;
    done0 = done_cnt;
    wr(ADDR_CHOFF, off);
    wr(ADDR_CTRL, {2'h3, s, 4'h0});
    n = 0;
    while (adc_enabled !== 1'b0 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    idle(6);
    chk_en(1'b0);
    for (int i = 0; i < 8; i++) chk({7'h0, ~off[i] & CHAN_PRESENT[i]}, 8'(cnt[i]));
    chk({7'h0, ~m}, 8'(done_cnt - done0));
    rd(ADDR_CTRL, {2'h1, s, 4'h0});
  endtask : one_shot

  task automatic chk_results;
    rd(ADDR_IIN_HI, {negs[7], 3'h0, vals[7][11:8]});
    rd(ADDR_IIN_LO, vals[7][7:0]);
    rd(ADDR_ICHG_HI, {4'h0, vals[6][11:8]});
    rd(ADDR_ICHG_LO, vals[6][7:0]);
    rd(ADDR_VIN_HI, {3'h0, vals[5][12:8]});
    rd(ADDR_VIN_LO, vals[5][7:0]);
  endtask : chk_results

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, rd_taken} = '0;
    {watchdog_expired, input_overvoltage_threshold, adc_done_mask} = '0;
    {conv_ready, conv_value, conv_negative} = '0;
    errors = 0;
    total_checks = 0;
    done_cnt = 0;
    void'($urandom(32'hf023));
    idle(5);
    rst = 1'b0;
    chk_en(1'b0);
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_CHOFF, CHOFF_RST);
    for (logic [7:0] a = ADDR_IIN_HI; a <= ADDR_VIN_LO; a++) rd(a, BYTE_ZERO);
    rd(8'h40, BYTE_ZERO);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL, {2'h0, 2'(s), 4'h0});
      rd(ADDR_CTRL, {2'h0, 2'(s), 4'h0});
      chk(8'(15 - s), {4'h0, conv_res_bits});
    end
    wr(ADDR_IIN_HI, 8'hff);
    wr(ADDR_VIN_LO, 8'hff);
    rd(ADDR_IIN_HI, BYTE_ZERO);
    rd(ADDR_VIN_LO, BYTE_ZERO);
    off_r = 8'($urandom) & CHAN_PRESENT;
    wr(ADDR_CHOFF, off_r);
    rd(ADDR_CHOFF, off_r);
    one_shot(8'h1d, 1'b0, 2'($urandom));
    chk_results();
    one_shot(8'h00, 1'b1, 2'h3);
    chk_results();
    // continuous mode keeps looping until the watchdog stops it
    adc_done_mask = 1'b0;
    done0 = done_cnt;
    for (int i = 0; i < 8; i++) cnt[i] = 0;
    wr(ADDR_CTRL, 8'h80);
    n = 0;
    while (cnt[0] < 2 && n < 600) begin
      @(negedge ref_clk);
      n++;
    end
    chk(8'h02, 8'(cnt[0]));
    chk(8'h00, 8'(done_cnt - done0));
    watchdog_expired = 1'b1;
    @(negedge ref_clk);
    watchdog_expired = 1'b0;
    @(negedge ref_clk);
    chk_en(1'b0);
    rd(ADDR_CTRL, 8'h00);
    idle(6);
    cnt[7] = 0;
    idle(20);
    chk(8'h00, 8'(cnt[7]));
    // over-voltage clears the enable and keeps it clear
    wr(ADDR_CTRL, 8'h80);
    input_overvoltage_threshold = 1'b1;
    idle(5);
    chk_en(1'b0);
    wr(ADDR_CTRL, 8'h80);
    idle(2);
    chk_en(1'b0);
    input_overvoltage_threshold = 1'b0;
    idle(6);
    chk_en(1'b0);
    wr(ADDR_CTRL, 8'h80);
    @(negedge ref_clk);
    chk_en(1'b1);
    wr(ADDR_CTRL, 8'h00);
    idle(8);
    // register reset returns everything to defaults
    wr(ADDR_CHOFF, 8'h5c);
    wr(ADDR_CTRL, 8'h50);
    wr(ADDR_REGRST, 8'h80);
    idle(3);
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_CHOFF, CHOFF_RST);
    for (logic [7:0] a = ADDR_IIN_HI; a <= ADDR_VIN_LO; a++) rd(a, BYTE_ZERO);
    rd(ADDR_REGRST, BYTE_ZERO);
    idle(4);
    // a reset in mid-scan drops the enable and restores defaults
    wr(ADDR_CTRL, 8'h80);
    idle(7);
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    chk_en(1'b0);
    chk({4'h0, RES_12}, {4'h0, conv_res_bits});
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_IIN_LO, BYTE_ZERO);
    idle(4);
    end_of_test();
  end
endmodule : adccr_core_tb
